// >>> core/polled_input_monitor.sv
// Purpose: poll monitored pins between instructions and run the response
// Assumes: pins synchronous to clk; instr_done marks instruction boundary
// Notes: status bytes readable by scratchpad address 128..135
// Summary of operation
// - pin selector 0..15 per input; configured pin forced to input.
// - per-pin active level bit: 0 watches low, 1 watches high.
// - sample all monitored pins once after each instruction, before fetch.
// - per poll: nothing, outputs, run slot on detection, stall until detection, or any mix.
// - poll status kept at scratchpad locations 128 through 135.
// - both banks' pins checked every poll regardless of selected bank.
// - response chosen by mode, output and run settings, not input setup.
// - any monitored pin active meets the poll condition (logical OR).
module polled_input_monitor
    import poll_pkg::*;
(
    input wire logic clk,                  // clock
    input wire logic rst,                  // async reset, high
    input wire logic cfg_in_we,            // poll_input_config strobe
    input wire logic cfg_in_bank,          // bank of configured pin
    input wire logic [3:0] cfg_in_pin,     // pin selector
    input wire logic cfg_in_level,         // active level
    input wire logic cfg_clear,            // drop all monitored pins
    input wire logic mode_out_en,          // poll_mode_select: drive outputs
    input wire logic mode_latch,           // poll_mode_select: latch outputs
    input wire logic mode_run_en,          // poll_mode_select: run slot
    input wire logic mode_enable,          // poll_mode_select: polling on
    input wire logic poll_wait_command,    // stall until condition
    input wire logic [31:0] out_mask,      // poll_output_config pins, 2 banks
    input wire logic [31:0] out_level,     // poll_output_config levels
    input wire logic [2:0] poll_run_config, // program slot to launch
    input wire logic instr_done,           // instruction completed pulse
    input wire logic [15:0] pins_main,     // bank 0 pin levels
    input wire logic [15:0] pins_aux,      // bank 1 pin levels
    input wire logic [7:0] sp_addr,        // scratchpad read address
    output logic [7:0] sp_rdata,           // scratchpad status byte
    output logic sp_hit,                   // address in status range
    output logic [31:0] dir_input,         // pins forced to input
    output logic [31:0] out_drive,         // polled output values
    output logic [31:0] out_oe,            // polled output enables
    output logic run_req,                  // launch program pulse
    output logic [2:0] run_slot,           // slot to launch
    output logic fetch_hold,               // stall next fetch
    output logic poll_active               // last poll met condition
);
    ////////////////////////////////////////////////////////////////////////
    // registered state of the monitor
    typedef struct packed {
        poll_state_e state;
        logic [31:0] mask;
        logic [31:0] level;
        logic [31:0] drive;
        logic [31:0] oe;
        logic [15:0] hit_main;
        logic [15:0] hit_aux;
        logic active;
        logic latched;
        logic run;
        logic [2:0] slot;
        logic [7:0] rdata;
    } mon_s;

    mon_s cur_ff;
    mon_s nxt_cur;
    logic [15:0] hit_m;
    logic [15:0] hit_a;
    logic any_hit;
    logic [4:0] cfg_idx;
    logic [31:0] cfg_mask;
    logic [31:0] cfg_level;
    logic in_poll;
    logic in_wait;
    logic poll_take;
    logic sample_now;
    logic mode_drop;
    logic resp_hold;
    logic resp_latch;
    logic resp_run;
    logic resp_stall;
    logic [31:0] resp_drive;
    logic in_range;
    logic [7:0] rd_byte;
    logic [7:0] status_b [STATUS_WORDS];

    ////////////////////////////////////////////////////////////////////////
    // one level compare per bank
    pin_match u_main (
        .pins(pins_main),
        .mask(cur_ff.mask[15:0]),
        .level(cur_ff.level[15:0]),
        .hit(hit_m)
    );
    pin_match u_aux (
        .pins(pins_aux),
        .mask(cur_ff.mask[31:16]),
        .level(cur_ff.level[31:16]),
        .hit(hit_a)
    );

    // both banks always take part, whatever bank the program uses
    assign any_hit = |{hit_m, hit_a};

    ////////////////////////////////////////////////////////////////////////
    // pin set-up: flat index is bank * 16 + pin; clear wins over add
    assign cfg_idx = {cfg_in_bank, cfg_in_pin};

    always_comb begin
        cfg_mask = cur_ff.mask;
        cfg_level = cur_ff.level;
        if (cfg_clear) begin
            cfg_mask = {MASK_RESET, MASK_RESET};
            cfg_level = {LEVEL_RESET, LEVEL_RESET};
        end else if (cfg_in_we) begin
            cfg_mask[cfg_idx] = 1'b1;
            cfg_level[cfg_idx] = cfg_in_level;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // poll points: once per finished instruction, every cycle when stalled
    assign in_poll = (cur_ff.state == ST_POLL);
    assign in_wait = (cur_ff.state == ST_WAIT);
    assign poll_take = in_poll && mode_enable && instr_done;
    assign sample_now = poll_take || in_wait;
    assign mode_drop = !mode_enable && (cur_ff.state != ST_IDLE);

    ////////////////////////////////////////////////////////////////////////
    // response decode: mode, output and run set-up choose it
    always_comb begin
        resp_hold = mode_latch && cur_ff.latched;
        resp_latch = mode_latch && any_hit;
        resp_drive = any_hit ? out_level : ~out_level;
        resp_run = mode_run_en && any_hit;
        resp_stall = poll_wait_command && !any_hit;
    end

    ////////////////////////////////////////////////////////////////////////
    // next state of the monitor
    always_comb begin
        nxt_cur = cur_ff;
        nxt_cur.run = 1'b0;
        nxt_cur.mask = cfg_mask;
        nxt_cur.level = cfg_level;
        nxt_cur.rdata = rd_byte;
        if (sample_now) begin
            nxt_cur.hit_main = hit_m;
            nxt_cur.hit_aux = hit_a;
            nxt_cur.active = any_hit;
        end
        unique case (cur_ff.state)
            ST_IDLE: begin
                if (mode_enable) begin
                    nxt_cur.state = ST_POLL;
                end
            end
            ST_POLL: begin
                if (poll_take && mode_out_en) begin
                    nxt_cur.oe = out_mask;
                    if (!resp_hold) begin
                        nxt_cur.drive = resp_drive;
                    end
                    if (resp_latch) begin
                        nxt_cur.latched = 1'b1;
                    end
                end
                if (poll_take && resp_run) begin
                    nxt_cur.run = 1'b1;
                    nxt_cur.slot = poll_run_config;
                end
                if (poll_take && resp_stall) begin
                    nxt_cur.state = ST_WAIT;
                end
            end
            ST_WAIT: begin
                // stall ends on the first cycle a pin is active
                if (any_hit) begin
                    nxt_cur.state = ST_POLL;
                end
            end
            default: begin
                nxt_cur.state = ST_IDLE;
            end
        endcase
        // polling off drops the stall, the latch and the output enables
        if (mode_drop) begin
            nxt_cur.state = ST_IDLE;
            nxt_cur.latched = 1'b0;
            nxt_cur.oe = 32'h0000_0000;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cur_ff <= '0;
        end else begin
            cur_ff <= nxt_cur;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // status image of scratchpad bytes 128..135
    always_comb begin
        status_b[0] = cur_ff.hit_main[7:0];
        status_b[1] = cur_ff.hit_main[15:8];
        status_b[2] = cur_ff.hit_aux[7:0];
        status_b[3] = cur_ff.hit_aux[15:8];
        status_b[4] = {4'h0, cur_ff.latched, cur_ff.run, cur_ff.active,
                       mode_enable};
        status_b[5] = {5'h00, cur_ff.slot};
        status_b[6] = {6'h00, cur_ff.state};
        status_b[7] = BYTE_RESET;
    end

    assign in_range = (sp_addr >= STATUS_FIRST) && (sp_addr <= STATUS_LAST);

    // base is aligned to eight, so the low bits pick the byte
    always_comb begin
        rd_byte = BYTE_RESET;
        if (in_range) begin
            rd_byte = status_b[sp_addr[2:0]];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    assign sp_hit = in_range;
    assign sp_rdata = cur_ff.rdata;
    assign dir_input = cur_ff.mask;
    assign out_drive = cur_ff.drive;
    // an output enable never reaches a monitored input
    assign out_oe = cur_ff.oe & ~cur_ff.mask;
    assign run_req = cur_ff.run;
    assign run_slot = cur_ff.slot;
    assign fetch_hold = in_wait;
    assign poll_active = cur_ff.active;
endmodule : polled_input_monitor

// >>> core/poll_pkg.sv
// Purpose: constants and types for the polled input monitor
// Assumes: 16 pins per bank, two banks
// Notes: status image mirrors scratchpad words 128..135
package poll_pkg;
    localparam int unsigned NUM_PINS = 16;
    localparam int unsigned NUM_BANKS = 2;
    localparam int unsigned PIN_SEL_W = 4;
    localparam logic [7:0] STATUS_FIRST = 8'h80;
    localparam logic [7:0] STATUS_LAST = 8'h87;
    localparam int unsigned STATUS_WORDS = 8;
    localparam logic [15:0] MASK_RESET = 16'h0000;
    localparam logic [15:0] LEVEL_RESET = 16'h0000;
    localparam logic [7:0] BYTE_RESET = 8'h00;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_POLL = 2'b01,
        ST_WAIT = 2'b10
    } poll_state_e;
endpackage : poll_pkg

// >>> core/pin_match.sv
// Purpose: per-bank active level comparison of monitored pins
// Assumes: level bit 0 watches low, 1 watches high
// Notes: combinational
module pin_match
    import poll_pkg::*;
(
    input wire logic [15:0] pins,  // sampled pin levels
    input wire logic [15:0] mask,  // monitored pins
    input wire logic [15:0] level, // active level per pin
    output logic [15:0] hit        // pin at its active level
);
    assign hit = mask & ~(pins ^ level);
endmodule : pin_match

// >>> test/poll_pins_model.sv
// Purpose: external pin levels seen by the monitor
// Assumes: bench sets levels at the falling edge
// Notes: bank 1 in upper half
module poll_pins_model (
    input wire logic [31:0] lvl, // wanted levels
    output logic [15:0] pins_main, // bank 0
    output logic [15:0] pins_aux // bank 1
);
    timeunit 1ns;
    timeprecision 1ps;
    assign pins_main = lvl[15:0];
    assign pins_aux = lvl[31:16];
endmodule : poll_pins_model

// >>> test/polled_input_monitor_sva.sv
// Purpose: port checks for the polled input monitor
// Assumes: one clock, async high reset
// Notes: bound below
module poll_mon_sva
    import poll_pkg::*;
(
    input wire logic clk, // clock
    input wire logic rst, // reset
    input wire logic mode_enable, // polling on
    input wire logic mode_run_en, // run slot
    input wire logic instr_done, // boundary
    input wire logic [7:0] sp_addr, // address
    input wire logic [7:0] sp_rdata, // status
    input wire logic sp_hit, // in range
    input wire logic [31:0] dir_input, // inputs
    input wire logic [31:0] out_oe, // enables
    input wire logic run_req, // launch
    input wire logic fetch_hold, // stall
    input wire logic poll_active // met
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    chk_oe_input: assert property (
        (out_oe & dir_input) == 32'h0000_0000)
        else $error("oe on input pin");
    chk_run_pulse: assert property (
        run_req |=> !run_req || $past(instr_done && mode_run_en))
        else $error("run pulse too long");
    chk_run_cause: assert property (
        $rose(run_req) |-> $past(mode_run_en))
        else $error("run without run mode");
    chk_sp_hit: assert property (
        sp_hit == (sp_addr >= STATUS_FIRST && sp_addr <= STATUS_LAST))
        else $error("status range wrong");
    chk_sp_zero: assert property (
        !sp_hit |=> sp_rdata == 8'h00)
        else $error("outside status not zero");
    chk_oe_off: assert property (
        !mode_enable ##1 !mode_enable |-> out_oe == 32'h0000_0000)
        else $error("oe kept with polling off");
    chk_hold_idle: assert property (
        !mode_enable ##1 !mode_enable |-> !fetch_hold)
        else $error("stall with polling off");
    chk_poll_step: assert property (
        $rose(poll_active) && !$past(fetch_hold)
        |-> $past(instr_done) || $past(instr_done, 2))
        else $error("poll off boundary");
endmodule : poll_mon_sva
bind polled_input_monitor poll_mon_sva poll_mon_sva_inst (.clk(clk),
    .rst(rst), .mode_enable(mode_enable), .mode_run_en(mode_run_en),
    .instr_done(instr_done), .sp_addr(sp_addr), .sp_rdata(sp_rdata),
    .sp_hit(sp_hit), .dir_input(dir_input), .out_oe(out_oe),
    .run_req(run_req), .fetch_hold(fetch_hold),
    .poll_active(poll_active));

// >>> test/tb_polled_input_monitor.sv
// Purpose: scenario bench for the polled input monitor
// Assumes: inputs change at the falling edge
// Notes: outputs checked two cycles after each poll() strobe ends; t_run checks run_req as its strobe ends
module tb_polled_input_monitor;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, rst = 1'b1, we = 1'b0, bank = 1'b0, lv = 1'b0;
    logic men = 1'b0, oen = 1'b0, ren = 1'b0, wt = 1'b0, done = 1'b0;
    logic clr = 1'b0, lat = 1'b0, run_req, fetch_hold, poll_active, sp_hit;
    logic [3:0] pin = 4'h0;
    logic [2:0] run_slot;
    logic [7:0] sp_addr = 8'h00, sp_rdata;
    logic [15:0] pm, pa;
    logic [31:0] lvl = 32'hffff_ffff, dir_input, out_drive, out_oe;
    int bad_count = 0, check_count = 0;
    initial forever #2 clk = ~clk;
    poll_pins_model poll_pins_model_inst (.lvl(lvl), .pins_main(pm),
        .pins_aux(pa));
    polled_input_monitor polled_input_monitor_inst (.clk(clk), .rst(rst),
        .cfg_in_we(we), .cfg_in_bank(bank), .cfg_in_pin(pin),
        .cfg_in_level(lv), .cfg_clear(clr), .mode_out_en(oen),
        .mode_latch(lat), .mode_run_en(ren), .mode_enable(men),
        .poll_wait_command(wt), .out_mask(32'h0000_00f0),
        .out_level(32'h0000_0050), .poll_run_config(3'h5),
        .instr_done(done), .pins_main(pm), .pins_aux(pa),
        .sp_addr(sp_addr), .sp_rdata(sp_rdata), .sp_hit(sp_hit),
        .dir_input(dir_input), .out_drive(out_drive), .out_oe(out_oe),
        .run_req(run_req), .run_slot(run_slot), .fetch_hold(fetch_hold),
        .poll_active(poll_active));
    task automatic chk(input string n, input logic [31:0] e,
                       input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask : tick
    task automatic final_report;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : final_report
    task automatic add(input logic b, input logic [3:0] p, input logic l);
        {bank, pin, lv, we} = {b, p, l, 1'b1};
        tick(1);
        we = 1'b0;
    endtask : add
    task automatic poll;
        done = 1'b1;
        tick(1);
        done = 1'b0;
        tick(2);
    endtask : poll
    task automatic t_out;
        add(1'b0, 4'h0, 1'b0);
        {men, oen} = 2'b11;
        tick(2);
        lvl[0] = 1'b0;
        poll();
        chk("dir", 32'h0000_0001, dir_input);
        chk("active", 32'h1, 32'(poll_active));
        chk("oe", 32'h0000_00f0, out_oe);
        chk("drive", 32'h0000_0050, out_drive & 32'h0000_00f0);
        lvl[0] = 1'b1;
        tick(3);
        chk("between", 32'h1, 32'(poll_active));
        poll();
        chk("inactive", 32'h0, 32'(poll_active));
    endtask : t_out
    task automatic t_aux;
        sp_addr = 8'h83;
        add(1'b1, 4'hf, 1'b1);
        poll();
        chk("dir2", 32'h8000_0001, dir_input);
        chk("aux or", 32'h1, 32'(poll_active));
        chk("aux byte", 32'h80, 32'(sp_rdata));
        lvl[31] = 1'b0;
        poll();
        chk("none", 32'h0, 32'(poll_active));
        chk("aux clear", 32'h0, 32'(sp_rdata));
    endtask : t_aux
    task automatic t_run;
        {ren, lvl[31], done} = 3'b111;
        tick(1);
        done = 1'b0;
        for (int i = 0; i < 4 && run_req !== 1'b1; i++) tick(1);
        if (run_req !== 1'b1) begin
            chk("run wait", 32'h1, 32'(run_req));
            final_report();
        end
        chk("slot", 32'h5, 32'(run_slot));
        tick(1);
        chk("pulse", 32'h0, 32'(run_req));
        ren = 1'b0;
    endtask : t_run
    task automatic t_latch;
        {lat, sp_addr} = {1'b1, 8'h84};
        poll();
        chk("held", 32'h0000_0050, out_drive & 32'h0000_00f0);
        chk("ctl byte", 32'h0b, 32'(sp_rdata));
        lvl[31] = 1'b0;
        poll();
        chk("frozen", 32'h0000_0050, out_drive & 32'h0000_00f0);
        lat = 1'b0;
        poll();
        chk("free", 32'h0000_00a0, out_drive & 32'h0000_00f0);
    endtask : t_latch
    task automatic t_wait;
        {wt, lvl[31]} = 2'b10;
        poll();
        chk("stall", 32'h1, 32'(fetch_hold));
        lvl[31] = 1'b1;
        tick(2);
        chk("go", 32'h0, 32'(fetch_hold));
        wt = 1'b0;
        sp_addr = 8'h87;
        tick(1);
        chk("hit", 32'h1, 32'(sp_hit));
        sp_addr = 8'h88;
        tick(1);
        chk("miss", 32'h0, 32'(sp_hit));
        chk("zero", 32'h0, 32'(sp_rdata));
        {men, clr} = 2'b01;
        tick(2);
        chk("clear", 32'h0, dir_input);
        chk("oe off", 32'h0, out_oe);
    endtask : t_wait
    initial begin
        tick(20);
        rst = 1'b0;
        tick(1);
        t_out();
        t_aux();
        t_run();
        t_latch();
        t_wait();
        final_report();
    end
endmodule : tb_polled_input_monitor
